// ### verilog/tdsp_host.sv
// Host-side transfer engine driving the coprocessor memories per MAP decode.
//
// Behaviour
// (RULE1) Each transmit request first moves 16 configuration words to the config block.
// (RULE2) Configuration transfer is followed directly by systematic and parity data.
// (RULE3) Systematics go as 8-byte arrays; words twice ceil half frame length.
// (RULE4) Systematic transfer uses eight frames and 8-byte indexes.
// (RULE5) After systematics, next channel config only on first MAP, else a priori.
// (RULE6) A priori follows systematics for every MAP except the very first.
// (RULE7) A priori bytes: 8*ceil((FL+prolog)/8), two prologs for middle subframes.
// (RULE8) A priori completion raises a done pulse, then waits for next channel.
// (RULE9) Extrinsics read from base, offset by prolog for middle and last.
// (RULE10) Extrinsic read length is 8*ceil(FL/8) bytes in one array.
// (RULE11) After extrinsics, next ready channel or stop with null link.
// (RULE12) Software programs frame length without tail information.
// (RULE13) A maximum iteration count of zero means 32 iterations.
// (RULE14) Shared mode keeps stopping criteria, prolog reduction, scaling disabled.
// (RULE15) Correction bit selects max-log-MAP or full log-MAP.
// (RULE16) Minimum iteration count is between 1 and 31.
// (RULE17) Input sign invert bit negates channel samples.
// (RULE18) Output bit order selects hard-decision packing direction.
// (RULE19) Subframe select is 2 first, 4 middle, 6 last.
// (RULE20) Systematic source buffer must be double-word aligned.
// (RULE21) Interleaver load request in shared mode flags an error.
// (RULE22) Output parameter request in shared mode flags an error.
// (RULE23) Frame length limits per subframe kind are checked by the device.
// (RULE24) Reliability length other than 128 flags an error for first/middle.
// (RULE25) Device raises one event per awaited transfer, in decode order.
// (RULE26) Steps run config, systematics, a priori when needed, then extrinsics.
//
// Added by the designer: the AXI4-Lite register port.
`include "tdsp_params.svh"
module tdsp_host #(
   parameter int ADDR_W = 32,
   parameter int FL_W = 15
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [5:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [5:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   input wire logic transmit_request_event,
   input wire logic receive_request_event,
   output logic [ADDR_W-1:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic mem_write,
   output logic mem_read,
   input wire logic [31:0] mem_rdata,
   output logic [ADDR_W-1:0] user_addr,
   output logic [31:0] user_wdata,
   output logic user_write,
   output logic user_read,
   input wire logic [31:0] user_rdata,
   output logic map_done
);
   import tdsp_pkg::*;
   if (ADDR_W != 32 || FL_W < 15 || FL_W > 16)
   begin
      $error("tdsp_host: unsupported parameter values");
   end

   // ==========================================================
   // Length arithmetic
   // ==========================================================
   function automatic logic [17:0] round8(input logic [17:0] n);
      round8 = (n + 18'h7) & ~18'h7;
   endfunction

   // ==========================================================
   // Register file
   // ==========================================================
   logic [31:0] cfg0_r, sp_src_r, ap_src_r, ext_dst_r, cfg_src_r;
   logic [15:0] prolog_r;
   logic go_r, first_map_r, more_r, busy_r;
   logic [7:0] done_cnt_r;
   logic aw_hold_r, w_hold_r;
   logic [3:0] aw_idx_r;
   logic [31:0] w_data_r;
   tdsp_state_type state_r, state_nxt;

   wire [2:0] opmod = cfg0_r[`TDSP_OPMOD_LSB +: 3];
   wire [17:0] fl = 18'(cfg0_r[`TDSP_FL_LSB +: FL_W]); // RULE12
   wire [17:0] prol = {2'h0, prolog_r};
   wire is_middle = (opmod == `TDSP_OPMOD_MIDDLE);
   wire is_first_sub = (opmod == `TDSP_OPMOD_FIRST);
   wire cfg_bad = cfg0_r[`TDSP_INTERLEAVER_LOAD_REQUEST_BIT] | cfg0_r[`TDSP_OUTPUT_PARAM_REQUEST_BIT] |
      !(is_first_sub | is_middle | (opmod == `TDSP_OPMOD_LAST)); // RULE19
   wire sp_aligned = (sp_src_r[2:0] == 3'h0); // RULE20
   // Word count = 2*ceil(FL/2); bytes = 4 per word.
   wire [17:0] sp_bytes = ((fl + 18'h1) & ~18'h1) << 2; // RULE3
   wire [17:0] ap_bytes = round8(fl + prol + (is_middle ? prol : 18'h0)); // RULE7
   wire [17:0] ext_bytes = round8(fl); // RULE10
   wire [31:0] ext_src = `TDSP_EXT_BASE +
      (is_first_sub ? 32'h0 : {16'h0, prolog_r}); // RULE9

   wire aw_take = s_awvalid & s_awready;
   wire w_take = s_wvalid & s_wready;
   wire wr_fire = (aw_hold_r | aw_take) & (w_hold_r | w_take) & !s_bvalid;
   wire [3:0] wr_idx = aw_take ? s_awaddr[5:2] : aw_idx_r;
   wire [31:0] wr_dat = w_take ? s_wdata : w_data_r;
   wire start_ok = !busy_r & sp_aligned & !cfg_bad;
   assign s_awready = !aw_hold_r & !s_bvalid;
   assign s_wready = !w_hold_r & !s_bvalid;
   assign s_arready = !s_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_idx_r <= 4'h0;
         w_data_r <= 32'h0;
         s_bvalid <= 1'b0;
         s_bresp <= `TDSP_RESP_OKAY;
      end
      else
      begin
         aw_hold_r <= wr_fire ? 1'b0 : (aw_hold_r | aw_take);
         w_hold_r <= wr_fire ? 1'b0 : (w_hold_r | w_take);
         if (aw_take)
            aw_idx_r <= s_awaddr[5:2];
         if (w_take)
            w_data_r <= s_wdata;
         if (wr_fire)
         begin
            s_bvalid <= 1'b1;
            s_bresp <= (wr_idx < `TDSP_REG_COUNT) ? `TDSP_RESP_OKAY
               : `TDSP_RESP_SLVERR;
         end
         else if (s_bready)
            s_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg0_r <= 32'h0;
         sp_src_r <= 32'h0;
         ap_src_r <= 32'h0;
         ext_dst_r <= 32'h0;
         cfg_src_r <= 32'h0;
         prolog_r <= 16'h0;
         go_r <= 1'b0;
         first_map_r <= 1'b0;
         more_r <= 1'b0;
      end
      else
      begin
         go_r <= wr_fire && wr_idx == `TDSP_REG_CTRL && wr_dat[0] && start_ok;
         if (wr_fire && wr_idx == `TDSP_REG_CTRL && start_ok)
         begin
            first_map_r <= wr_dat[1];
            more_r <= wr_dat[2];
         end
         if (wr_fire && wr_idx == `TDSP_REG_CFG0 && !busy_r)
            cfg0_r <= wr_dat;
         if (wr_fire && wr_idx == `TDSP_REG_SPSRC && !busy_r)
            sp_src_r <= wr_dat;
         if (wr_fire && wr_idx == `TDSP_REG_APSRC && !busy_r)
            ap_src_r <= wr_dat;
         if (wr_fire && wr_idx == `TDSP_REG_EXTDST && !busy_r)
            ext_dst_r <= wr_dat;
         if (wr_fire && wr_idx == `TDSP_REG_PROLOG && !busy_r)
            prolog_r <= wr_dat[15:0];
         if (wr_fire && wr_idx == `TDSP_REG_CFGSRC && !busy_r)
            cfg_src_r <= wr_dat;
      end
   end

   // Read channel.
   wire [31:0] stat_word = {16'h0, done_cnt_r, 1'b0, state_r};
   wire [3:0] rd_idx = s_araddr[5:2];
   wire [31:0] rd_mux =
      (rd_idx == `TDSP_REG_CTRL) ? {29'h0, more_r, first_map_r, 1'b0} :
      (rd_idx == `TDSP_REG_STAT) ? stat_word :
      (rd_idx == `TDSP_REG_CFG0) ? cfg0_r :
      (rd_idx == `TDSP_REG_SPSRC) ? sp_src_r :
      (rd_idx == `TDSP_REG_APSRC) ? ap_src_r :
      (rd_idx == `TDSP_REG_EXTDST) ? ext_dst_r :
      (rd_idx == `TDSP_REG_PROLOG) ? {16'h0, prolog_r} :
      (rd_idx == `TDSP_REG_CFGSRC) ? cfg_src_r : 32'h0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0;
         s_rresp <= `TDSP_RESP_OKAY;
      end
      else if (s_arvalid && s_arready)
      begin
         s_rvalid <= 1'b1;
         s_rdata <= rd_mux;
         s_rresp <= (rd_idx < `TDSP_REG_COUNT) ? `TDSP_RESP_OKAY
            : `TDSP_RESP_SLVERR;
      end
      else if (s_rready)
         s_rvalid <= 1'b0;
   end

   // ==========================================================
   // Transfer sequencer
   // ==========================================================
   logic [17:0] cnt_r;
   logic rd_phase_r;
   logic [31:0] data_r;
   wire [17:0] total = (state_r == TDSP_CFG) ? 18'd64 :
      (state_r == TDSP_SP) ? sp_bytes :
      (state_r == TDSP_AP) ? ap_bytes : ext_bytes;
   wire last_word = (cnt_r + 18'd4 >= total);
   wire moving = (state_r == TDSP_CFG) | (state_r == TDSP_SP) |
      (state_r == TDSP_AP) | (state_r == TDSP_EXT);
   wire beat = moving & rd_phase_r;

   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         TDSP_IDLE:
            if (go_r)
               state_nxt = TDSP_WAIT_X;
         TDSP_WAIT_X:
            if (transmit_request_event) // RULE25
               state_nxt = TDSP_CFG; // RULE1 RULE26
         TDSP_CFG:
            if (beat && last_word)
               state_nxt = TDSP_SP; // RULE2
         TDSP_SP:
            if (beat && last_word)
               // A priori is skipped only on the very first MAP.
               state_nxt = first_map_r ? TDSP_WAIT_R : TDSP_AP; // RULE5 RULE6
         TDSP_AP:
            if (beat && last_word)
               state_nxt = TDSP_WAIT_R; // RULE8
         TDSP_WAIT_R:
            if (receive_request_event)
               state_nxt = TDSP_EXT;
         TDSP_EXT:
            if (beat && last_word)
               state_nxt = more_r ? TDSP_WAIT_X : TDSP_IDLE; // RULE11
      endcase
   end

   // Each beat reads one word from the source, then writes it out.
   wire [31:0] off = {14'h0, cnt_r};
   always_comb
   begin
      mem_addr = 32'h0;
      user_addr = 32'h0;
      mem_write = 1'b0;
      mem_read = 1'b0;
      user_write = 1'b0;
      user_read = 1'b0;
      unique case (state_r)
         TDSP_CFG:
         begin
            // Configuration words go across unchanged; software owns them.
            user_addr = cfg_src_r + off; // RULE14 RULE16
            user_read = !rd_phase_r;
            mem_addr = `TDSP_CFG_BASE + off; // RULE1
            mem_write = rd_phase_r;
         end
         TDSP_SP:
         begin
            // Eight-byte arrays with 8-byte strides are a linear copy.
            user_addr = sp_src_r + off; // RULE4
            user_read = !rd_phase_r;
            mem_addr = `TDSP_SP_BASE + off; // RULE3
            mem_write = rd_phase_r;
         end
         TDSP_AP:
         begin
            user_addr = ap_src_r + off;
            user_read = !rd_phase_r;
            mem_addr = `TDSP_AP_BASE + off; // RULE7
            mem_write = rd_phase_r;
         end
         TDSP_EXT:
         begin
            mem_addr = ext_src + off; // RULE9
            mem_read = !rd_phase_r;
            user_addr = ext_dst_r + off; // RULE10
            user_write = rd_phase_r;
         end
         default:
         begin
            mem_addr = 32'h0;
         end
      endcase
   end
   assign mem_wdata = data_r;
   assign user_wdata = data_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_r <= TDSP_IDLE;
         cnt_r <= 18'h0;
         rd_phase_r <= 1'b0;
         data_r <= 32'h0;
         busy_r <= 1'b0;
         map_done <= 1'b0;
         done_cnt_r <= 8'h0;
      end
      else
      begin
         state_r <= state_nxt;
         busy_r <= (state_nxt != TDSP_IDLE);
         rd_phase_r <= moving & !rd_phase_r & (state_nxt == state_r);
         if (moving && !rd_phase_r)
            data_r <= (state_r == TDSP_EXT) ? mem_rdata : user_rdata;
         cnt_r <= (state_nxt != state_r) ? 18'h0 :
            (beat ? cnt_r + 18'd4 : cnt_r);
         map_done <= (state_r == TDSP_AP) & beat & last_word; // RULE8
         if (state_r == TDSP_EXT && beat && last_word)
            done_cnt_r <= done_cnt_r + 8'h1;
      end
   end
endmodule

// ### verilog/tdsp_params.svh
// Constants for the shared-mode turbo decoder host transfer sequencer.
`ifndef TDSP_PARAMS_SVH
`define TDSP_PARAMS_SVH
`define TDSP_CFG_BASE 32'h5000_0000
`define TDSP_SP_BASE 32'h5001_0000
`define TDSP_EXT_BASE 32'h5003_0000
`define TDSP_AP_BASE 32'h5004_0000
`define TDSP_CFG_WORDS 5'd16
`define TDSP_SP_ARRAY_BYTES 16'd8
`define TDSP_OPMOD_FIRST 3'h2
`define TDSP_OPMOD_MIDDLE 3'h4
`define TDSP_OPMOD_LAST 3'h6
`define TDSP_OPMOD_LSB 1
`define TDSP_INTERLEAVER_LOAD_REQUEST_BIT 4
`define TDSP_OUTPUT_PARAM_REQUEST_BIT 5
`define TDSP_FL_LSB 16
`define TDSP_REG_CTRL 4'h0
`define TDSP_REG_STAT 4'h1
`define TDSP_REG_CFG0 4'h2
`define TDSP_REG_SPSRC 4'h3
`define TDSP_REG_APSRC 4'h4
`define TDSP_REG_EXTDST 4'h5
`define TDSP_REG_PROLOG 4'h6
`define TDSP_REG_CFGSRC 4'h7
`define TDSP_REG_COUNT 4'h8
`define TDSP_RESP_OKAY 2'b00
`define TDSP_RESP_SLVERR 2'b10
`endif

// ### verilog/tdsp_pkg.sv
// Types for the shared-mode turbo decoder host transfer sequencer.
package tdsp_pkg;
   typedef enum logic [6:0] {
      TDSP_IDLE = 7'h01,
      TDSP_WAIT_X = 7'h02,
      TDSP_CFG = 7'h04,
      TDSP_SP = 7'h08,
      TDSP_AP = 7'h10,
      TDSP_WAIT_R = 7'h20,
      TDSP_EXT = 7'h40
   } tdsp_state_type;
endpackage

// ### bench/tdsp_host_sva.sv
// Port-level assertions for the host transfer engine.
module tdsp_host_sva #(
   parameter int ADDR_W = 32
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic mem_write,
   input wire logic mem_read,
   input wire logic [31:0] mem_rdata,
   input wire logic [31:0] user_wdata,
   input wire logic user_write,
   input wire logic user_read,
   input wire logic [31:0] user_rdata,
   input wire logic map_done
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // Region tracking
   // ==========================================================
   // Region code 3'h7 means no device write since reset.
   logic [2:0] last_rg_r;
   logic [ADDR_W-1:0] last_wa_r;
   wire logic [2:0] wr_rg = mem_addr[18:16];
   wire logic new_rg = mem_write && (wr_rg != last_rg_r);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         last_rg_r <= 3'h7;
      else if (mem_write)
         last_rg_r <= wr_rg;
   end
   always_ff @(posedge aclk)
   begin
      if (mem_write)
         last_wa_r <= mem_addr;
   end
   sequence s_word;
      ##1 mem_write ##1 !mem_write;
   endsequence
   // ==========================================================
   // Checks
   // ==========================================================
   AST_WORD_STEP: assert property (user_read |-> s_word)
      else $error("word copy step broken");
   AST_COPY_IN: assert property (
      user_read |=> mem_wdata == $past(user_rdata))
      else $error("device write data wrong");
   AST_COPY_OUT: assert property (
      mem_read |=> user_write && user_wdata == $past(mem_rdata))
      else $error("buffer write data wrong");
   AST_RD_SRC: assert property (
      mem_read |-> mem_addr[31:16] == 16'h5003)
      else $error("read outside extrinsics");
   AST_CFG_BASE: assert property (
      mem_write && wr_rg == 3'h0 |->
      mem_addr[31:16] == 16'h5000 && mem_addr[15:0] < 16'h0040)
      else $error("config write out of block");
   AST_ADDR_STEP: assert property (
      mem_write && !new_rg |-> mem_addr == last_wa_r + 'd4)
      else $error("address step wrong");
   AST_REGION_BASE: assert property (
      new_rg |-> mem_addr[15:0] == 16'h0)
      else $error("transfer not at base");
   AST_ORDER: assert property (new_rg |-> wr_rg == 3'h0 ||
      (wr_rg == 3'h1 && last_rg_r == 3'h0) ||
      (wr_rg == 3'h4 && last_rg_r == 3'h1))
      else $error("transfer order wrong");
   AST_DONE: assert property (
      map_done |-> last_rg_r == 3'h4 ##1 !map_done)
      else $error("done pulse wrong");
endmodule

bind tdsp_host tdsp_host_sva #(.ADDR_W(ADDR_W)) sva_u (.*);

// ### bench/tdsp_dev_model.sv
// Behavioural coprocessor model: memory port and request events.
module tdsp_dev_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] mem_addr,
   input wire logic mem_read,
   input wire logic mem_write,
   input wire logic kick,
   input wire logic [3:0] dly,
   output logic [31:0] mem_rdata,
   output logic transmit_request_event,
   output logic receive_request_event
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] tx_r, rx_r;
   logic [31:0] tog_r;
   // Idle read data toggles so a stale value never passes for data.
   assign mem_rdata = mem_read ? mem_addr ^ 32'h0f0f_0f0f : tog_r;
   always_ff @(posedge aclk)
   begin
      tog_r <= aresetn ? ~tog_r : 32'h5555_aaaa;
      transmit_request_event <= aresetn && tx_r == 5'd1;
      receive_request_event <= aresetn && rx_r == 5'd1;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn | kick)
         tx_r <= aresetn ? 5'(dly) + 5'd1 : 5'd0;
      else if (tx_r != 5'd0)
         tx_r <= tx_r - 5'd1;
   end
   // Extrinsics become ready once input writes have been quiet a while.
   always_ff @(posedge aclk)
   begin
      if (!aresetn | mem_write)
         rx_r <= aresetn ? 5'(dly) + 5'd6 : 5'd0;
      else if (rx_r != 5'd0)
         rx_r <= rx_r - 5'd1;
   end
endmodule

// ### bench/tdsp_host_bench.sv
// Self-checking bench for the host transfer engine with a device model.
module tdsp_host_bench;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(a, b) \
   begin \
      cmp_count++; \
      if ((a) !== (b)) \
      begin \
         errors++; \
         $display("[ERR] %0t got %0h want %0h", $time, a, b); \
      end \
   end
   typedef struct {
      logic [31:0] cfg0;
      logic [31:0] ctrl;
      int sp;
      int ap;
      int ex;
      logic [31:0] ea;
      logic [6:0] st;
   } tdsp_row_type;
   logic aclk = 0, aresetn = 0, kick = 0, s_awvalid = 0, s_wvalid = 0;
   logic s_bready = 0, s_arvalid = 0, s_rready = 0, s_awready, s_wready;
   logic s_bvalid, s_arready, s_rvalid, mem_write, mem_read, map_done;
   logic user_write, user_read, transmit_request_event;
   logic receive_request_event;
   logic [5:0] s_awaddr = 0, s_araddr = 0;
   logic [3:0] s_wstrb = 4'hf, dly = 0;
   logic [1:0] s_bresp, s_rresp, r;
   logic [31:0] s_wdata = 0, s_rdata, mem_addr, mem_wdata, mem_rdata, d, fr;
   logic [31:0] user_addr, user_wdata, user_rdata, fa[8], fd[8], ua;
   int errors = 0, cmp_count = 0, wc[8], rc, dn, n, uw;
   tdsp_row_type rows[4] = '{
      '{32'h0010_0004, 32'h3, 16, 0, 4, 32'h5003_0000, 7'h01},
      '{32'h0010_0008, 32'h1, 16, 8, 4, 32'h5003_0008, 7'h01},
      '{32'h0011_000c, 32'h1, 18, 8, 6, 32'h5003_0008, 7'h01},
      '{32'h0010_0004, 32'h7, 16, 0, 4, 32'h5003_0000, 7'h02}};
   tdsp_host dut_u (.*);
   tdsp_dev_model dev_u (.*);
   assign user_rdata = ~user_addr;
   always #20 aclk = ~aclk;
   always @(posedge aclk)
   begin
      if (mem_write && wc[mem_addr[18:16]]++ == 0)
      begin
         fa[mem_addr[18:16]] = mem_addr;
         fd[mem_addr[18:16]] = mem_wdata;
      end
      if (mem_read && rc++ == 0)
         fr = mem_addr;
      if (user_write && uw++ == 0)
         ua = user_addr;
      dn += map_done;
   end
   task automatic axw(input logic [5:0] a, input logic [31:0] v,
                      output logic [1:0] rs);
      logic ta, tw, bv;
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= v;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ta = s_awvalid & s_awready;
         tw = s_wvalid & s_wready;
         bv = s_bvalid;
         rs = s_bresp;
         @(posedge aclk);
         if (ta) s_awvalid <= 1'b0;
         if (tw) s_wvalid <= 1'b0;
      end while (!bv);
      s_bready <= 1'b0;
   endtask
   task automatic axr(input logic [5:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
      logic ta, rv;
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do
      begin
         @(negedge aclk);
         ta = s_arvalid & s_arready;
         rv = s_rvalid;
         v = s_rdata;
         rs = s_rresp;
         @(posedge aclk);
         if (ta) s_arvalid <= 1'b0;
      end while (!rv);
      s_rready <= 1'b0;
   endtask
   task automatic clr();
      wc = '{default: 0};
      rc = 0;
      dn = 0;
      uw = 0;
   endtask
   task automatic stop_test();
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge aclk);
      errors++;
      stop_test();
   end
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      axr(6'h04, d, r);
      `CHK(d, 32'h1)
      axr(6'h20, d, r);
      `CHK({r, d}, {2'b10, 32'h0})
      axw(6'h20, 32'h1, r);
      `CHK(r, 2'b10)
      for (n = 0; n < 4; n++)
      begin
         d = (n == 3) ? 32'h2 : 32'h0;
         axw(6'h08, 32'h0010_0004 | (32'h10 << n) & 32'h30 | d, r);
         axw(6'h0c, (n == 2) ? 32'h1004 : 32'h1000, r);
         axw(6'h00, 32'h1, r);
         axr(6'h04, d, r);
         `CHK(d[6:0], 7'h01)
      end
      for (n = 0; n < 5; n++)
         axw(6'(6'h0c + 4 * n), n == 3 ? 32'd8 : 32'h1000 * (n + 1), r);
      `CHK(r, 2'b00)
      foreach (rows[i])
      begin
         axw(6'h08, rows[i].cfg0, r);
         clr();
         axw(6'h00, rows[i].ctrl, r);
         dly <= 4'(i * 3);
         kick <= 1'b1;
         @(posedge aclk);
         kick <= 1'b0;
         for (n = 0; n < 3000 && rc < rows[i].ex; n++)
            @(posedge aclk);
         do
            axr(6'h04, d, r);
         while (d[6:0] === 7'h40 && n++ < 3000);
         `CHK(d[6:0], rows[i].st)
         `CHK(wc[0], 16)
         `CHK(fa[0], 32'h5000_0000)
         `CHK(wc[1], rows[i].sp)
         `CHK(fa[1], 32'h5001_0000)
         `CHK(wc[4], rows[i].ap)
         `CHK(dn, rows[i].ap ? 1 : 0)
         `CHK(rc, rows[i].ex)
         `CHK(fr, rows[i].ea)
         `CHK(ua, 32'h3000)
         `CHK(fd[0], ~32'h5000)
         `CHK(fd[1], ~32'h1000)
         if (rows[i].ap)
            `CHK(fd[4], ~32'h2000)
         `CHK(d[15:8], 8'(i + 1))
      end
      dly <= 4'h0;
      kick <= 1'b1;
      @(posedge aclk);
      kick <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b0;
      @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      clr();
      axr(6'h04, d, r);
      `CHK(d, 32'h1)
      `CHK(wc[0] + wc[1] + rc + uw, 0)
      stop_test();
   end
endmodule
